// ===== src/acsb_core.sv
// module: 8-bit core executing complement, compare, step and branch instructions
`timescale 1ns/10ps
`default_nettype none

module acsb_core #(
   parameter logic [acsb_pkg::PC_W-1:0] RESET_PC = acsb_pkg::RESET_PC
) (
   // clock and reset
   input  wire logic                       ref_clk,
   input  wire logic                       rst_n,
   // program memory, combinational read
   output logic [acsb_pkg::PC_W-1:0]       pm_addr,
   input  wire logic [7:0]                 pm_rdata,
   // data space memory, combinational read, write on we
   output acsb_pkg::acsb_ds_req_t          ds_req,
   input  wire logic [7:0]                 ds_rdata,
   // visible core state
   output acsb_pkg::acsb_stat_t            status
);

   // ----------------------------------------------------------------------------
   // opcode decode
   // ----------------------------------------------------------------------------
   // one place for the opcode map; used at fetch and nowhere else on purpose
   function automatic acsb_pkg::acsb_dec_t decode(input logic [7:0] op);
      acsb_pkg::acsb_dec_t d;
      d = '{kind: acsb_pkg::K_NONE, two_byte: 1'b0, loc: acsb_pkg::L_A};
      if (op == acsb_pkg::OP_INVERT)
         d = '{acsb_pkg::K_COM, 1'b0, acsb_pkg::L_A};
      else if (op == acsb_pkg::OP_CMP_DIR)
         d = '{acsb_pkg::K_CMP, 1'b1, acsb_pkg::L_DIR};
      else if (op == acsb_pkg::OP_CMP_IX)
         d = '{acsb_pkg::K_CMP, 1'b0, acsb_pkg::L_IX};
      else if (op == acsb_pkg::OP_CMP_IY)
         d = '{acsb_pkg::K_CMP, 1'b0, acsb_pkg::L_IY};
      else if (op == acsb_pkg::OP_CMP_IMM)
         d = '{acsb_pkg::K_CMP, 1'b1, acsb_pkg::L_IMM};
      else if (op == acsb_pkg::OP_DEC_DIR)
         d = '{acsb_pkg::K_DEC, 1'b1, acsb_pkg::L_DIR};
      else if (op == acsb_pkg::OP_DEC_IX)
         d = '{acsb_pkg::K_DEC, 1'b0, acsb_pkg::L_IX};
      else if (op == acsb_pkg::OP_DEC_IY)
         d = '{acsb_pkg::K_DEC, 1'b0, acsb_pkg::L_IY};
      else if (op[5:0] == acsb_pkg::OP_DEC_SHORT)
         d = '{acsb_pkg::K_DEC, 1'b0, acsb_pkg::acsb_loc_t'({2'b00, op[7:6]} + 4'h1)};
      else if (op == acsb_pkg::OP_INC_DIR)
         d = '{acsb_pkg::K_INC, 1'b1, acsb_pkg::L_DIR};
      else if (op == acsb_pkg::OP_INC_IX)
         d = '{acsb_pkg::K_INC, 1'b0, acsb_pkg::L_IX};
      else if (op == acsb_pkg::OP_INC_IY)
         d = '{acsb_pkg::K_INC, 1'b0, acsb_pkg::L_IY};
      else if (op[5:0] == acsb_pkg::OP_INC_SHORT)
         d = '{acsb_pkg::K_INC, 1'b0, acsb_pkg::acsb_loc_t'({2'b00, op[7:6]} + 4'h1)};
      else if (op[3:0] == acsb_pkg::OP_JP_LOW)
         d = '{acsb_pkg::K_JP, 1'b1, acsb_pkg::L_A};
      else if (op[2:0] == acsb_pkg::OP_JRC_LOW)
         d = '{acsb_pkg::K_JRC, 1'b0, acsb_pkg::L_A};
      return d;
   endfunction

   // ----------------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------------
   acsb_pkg::acsb_state_t      state_ff;
   logic [acsb_pkg::PC_W-1:0]  pc_ff;
   logic [7:0]                 op_ff;
   logic [7:0]                 arg_ff;
   acsb_pkg::acsb_kind_t       kind_ff;
   logic                       two_ff;
   acsb_pkg::acsb_loc_t        loc_ff;
   logic [7:0]                 acc_ff;
   logic [7:0]                 wreg_ff [4];   // x, y, v, w by index
   logic                       z_ff;
   logic                       c_ff;
   logic [7:0]                 ds_addr_ff;
   logic [7:0]                 ds_wdata_ff;
   logic                       ds_we_ff;
   logic                       ds_re_ff;
   logic                       bad_ff;

   // ----------------------------------------------------------------------------
   // datapath
   // ----------------------------------------------------------------------------
   wire acsb_pkg::acsb_dec_t   dec_now   = decode(pm_rdata);
   wire logic [1:0]            widx      = 2'(loc_ff - acsb_pkg::L_X);
   wire logic                  loc_wreg  = (loc_ff >= acsb_pkg::L_X) && (loc_ff <= acsb_pkg::L_W);
   // operand select: core register, data space word or immediate byte
   wire logic [7:0]            opnd      = (loc_ff == acsb_pkg::L_A)   ? acc_ff   :
                                           (loc_ff == acsb_pkg::L_MEM) ? ds_rdata :
                                           (loc_ff == acsb_pkg::L_IMM) ? arg_ff   :
                                           wreg_ff[widx];
   wire logic [8:0]            cmp_diff  = {1'b0, acc_ff} - {1'b0, opnd};
   wire logic [7:0]            step_res  = (kind_ff == acsb_pkg::K_INC) ? 8'(opnd + 8'h01)
                                                                        : 8'(opnd - 8'h01);
   wire logic [7:0]            res       = (kind_ff == acsb_pkg::K_COM) ? ~acc_ff : step_res;
   // zero flag: difference for compares, written result otherwise
   wire logic                  nxt_z     = (kind_ff == acsb_pkg::K_CMP) ? (cmp_diff[7:0] == 8'h00)
                                                                        : (res == 8'h00);
   // carry: old msb on invert, borrow on compare, kept on steps
   wire logic                  nxt_c     = (kind_ff == acsb_pkg::K_COM) ? acc_ff[7] :
                                           (kind_ff == acsb_pkg::K_CMP) ? cmp_diff[8] :
                                           c_ff;
   wire logic                  writes    = (kind_ff == acsb_pkg::K_COM) || (kind_ff == acsb_pkg::K_DEC) ||
                                           (kind_ff == acsb_pkg::K_INC);
   wire logic                  sets_flag = writes || (kind_ff == acsb_pkg::K_CMP);
   // pc already points past the opcode, so sext(e)+1 spans -15..+16
   wire logic [acsb_pkg::PC_W-1:0] rel_tgt = pc_ff + {{(acsb_pkg::PC_W-5){op_ff[7]}}, op_ff[7:3]};
   // low address nibble rides in the opcode, upper byte in the second byte
   wire logic [acsb_pkg::PC_W-1:0] abs_tgt = {pm_rdata, op_ff[7:4]};
   // direct address resolution: ffh is the accumulator, 80h..83h the working regs
   wire acsb_pkg::acsb_loc_t   dir_loc   = (pm_rdata == acsb_pkg::DS_ACC_ADDR) ? acsb_pkg::L_A :
                                           (pm_rdata[7:2] == acsb_pkg::DS_WREG_BASE) ?
                                           acsb_pkg::acsb_loc_t'({2'b00, pm_rdata[1:0]} + 4'h1) :
                                           acsb_pkg::L_MEM;

   // ----------------------------------------------------------------------------
   // sequencer and program counter
   // ----------------------------------------------------------------------------
   // four states give the four-cycle instructions; rel_branch_on_flag leaves after two
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= acsb_pkg::ST_FETCH;
         pc_ff    <= RESET_PC;
      end else begin
         case (state_ff)
            acsb_pkg::ST_FETCH: begin
               pc_ff    <= pc_ff + 12'h001;
               state_ff <= acsb_pkg::ST_ARG;
            end
            acsb_pkg::ST_ARG: begin
               if (kind_ff == acsb_pkg::K_JRC) begin
                  if (c_ff) begin
                     pc_ff <= rel_tgt;
                  end
                  state_ff <= acsb_pkg::ST_FETCH;
               end else begin
                  if (kind_ff == acsb_pkg::K_JP) begin
                     pc_ff <= abs_tgt;
                  end else if (two_ff) begin
                     pc_ff <= pc_ff + 12'h001;
                  end
                  state_ff <= acsb_pkg::ST_EXEC;
               end
            end
            acsb_pkg::ST_EXEC: state_ff <= acsb_pkg::ST_WB;
            acsb_pkg::ST_WB:   state_ff <= acsb_pkg::ST_FETCH;
            default:           state_ff <= acsb_pkg::ST_FETCH;
         endcase
      end
   end

   // ----------------------------------------------------------------------------
   // instruction latch and operand location
   // ----------------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         op_ff   <= 8'h00;
         arg_ff  <= 8'h00;
         kind_ff <= acsb_pkg::K_NONE;
         two_ff  <= 1'b0;
         loc_ff  <= acsb_pkg::L_A;
         bad_ff  <= 1'b0;
      end else if (state_ff == acsb_pkg::ST_FETCH) begin
         op_ff   <= pm_rdata;
         kind_ff <= dec_now.kind;
         two_ff  <= dec_now.two_byte;
         // indirect forms fetch through data space
         loc_ff  <= (dec_now.loc == acsb_pkg::L_IX || dec_now.loc == acsb_pkg::L_IY) ? acsb_pkg::L_MEM
                                                                                    : dec_now.loc;
         bad_ff  <= (dec_now.kind == acsb_pkg::K_NONE);
      end else begin
         bad_ff <= 1'b0;
         if (state_ff == acsb_pkg::ST_ARG && two_ff) begin
            arg_ff <= pm_rdata;
            if (loc_ff == acsb_pkg::L_DIR) begin
               loc_ff <= dir_loc;
            end
         end
      end
   end

   // ----------------------------------------------------------------------------
   // accumulator, working registers and flags
   // ----------------------------------------------------------------------------
   // results commit at the end of the execute cycle
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_ff <= 8'h00;
         z_ff   <= 1'b0;
         c_ff   <= 1'b0;
         for (int i = 0; i < 4; i++) begin
            wreg_ff[i] <= 8'h00;
         end
      end else if (state_ff == acsb_pkg::ST_EXEC) begin
         if (sets_flag) begin
            z_ff <= nxt_z;
            c_ff <= nxt_c;
         end
         if (writes && loc_ff == acsb_pkg::L_A) begin
            acc_ff <= res;
         end
         if (writes && loc_wreg) begin
            wreg_ff[widx] <= res;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // data space port
   // ----------------------------------------------------------------------------
   // address is set up a cycle early so the read data is settled in execute
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ds_addr_ff  <= 8'h00;
         ds_wdata_ff <= 8'h00;
         ds_we_ff    <= 1'b0;
         ds_re_ff    <= 1'b0;
      end else begin
         ds_we_ff <= 1'b0;
         ds_re_ff <= 1'b0;
         if (state_ff == acsb_pkg::ST_FETCH && dec_now.loc == acsb_pkg::L_IX) begin
            ds_addr_ff <= wreg_ff[0];
         end else if (state_ff == acsb_pkg::ST_FETCH && dec_now.loc == acsb_pkg::L_IY) begin
            ds_addr_ff <= wreg_ff[1];
         end else if (state_ff == acsb_pkg::ST_ARG && loc_ff == acsb_pkg::L_DIR) begin
            ds_addr_ff <= pm_rdata;
         end
         if (state_ff == acsb_pkg::ST_ARG && kind_ff != acsb_pkg::K_JRC && kind_ff != acsb_pkg::K_JP) begin
            ds_re_ff <= (loc_ff == acsb_pkg::L_MEM) || (loc_ff == acsb_pkg::L_DIR && dir_loc == acsb_pkg::L_MEM);
         end
         // write strobe stands during the last cycle only
         if (state_ff == acsb_pkg::ST_EXEC && writes && loc_ff == acsb_pkg::L_MEM) begin
            ds_we_ff    <= 1'b1;
            ds_wdata_ff <= res;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------------
   assign pm_addr                = pc_ff;
   assign ds_req.addr            = ds_addr_ff;
   assign ds_req.wdata           = ds_wdata_ff;
   assign ds_req.we              = ds_we_ff;
   assign ds_req.re              = ds_re_ff;
   assign status.acc             = acc_ff;
   assign status.null_result_bit = z_ff;
   assign status.arith_flag_bit  = c_ff;
   assign status.fetch           = (state_ff == acsb_pkg::ST_FETCH);  // opcode sampled this cycle
   assign status.bad_opcode      = bad_ff;

endmodule

`default_nettype wire

// ===== src/acsb_pkg.sv
// package: opcodes, decode types and port groups of the accumulator/step/branch core
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package acsb_pkg;

   localparam int PC_W = 12;
   localparam logic [PC_W-1:0] RESET_PC = 12'h000;

   // opcodes
   localparam logic [7:0] OP_INVERT      = 8'h2d;
   localparam logic [7:0] OP_CMP_DIR     = 8'h3f;
   localparam logic [7:0] OP_CMP_IX      = 8'h27;
   localparam logic [7:0] OP_CMP_IY      = 8'h2f;
   localparam logic [7:0] OP_CMP_IMM     = 8'h37;
   localparam logic [7:0] OP_DEC_DIR     = 8'hff;
   localparam logic [7:0] OP_DEC_IX      = 8'he7;
   localparam logic [7:0] OP_DEC_IY      = 8'hef;
   localparam logic [7:0] OP_INC_DIR     = 8'h7f;
   localparam logic [7:0] OP_INC_IX      = 8'h67;
   localparam logic [7:0] OP_INC_IY      = 8'h6f;
   localparam logic [5:0] OP_DEC_SHORT   = 6'h1d;  // low six bits, reg index in [7:6]
   localparam logic [5:0] OP_INC_SHORT   = 6'h15;
   localparam logic [3:0] OP_JP_LOW      = 4'h9;   // low nibble of abs_branch
   localparam logic [2:0] OP_JRC_LOW     = 3'h6;   // pattern 110 of rel_branch_on_flag

   // data space addresses that alias core registers
   localparam logic [7:0] DS_ACC_ADDR    = 8'hff;
   localparam logic [5:0] DS_WREG_BASE   = 6'h20;  // 80h..83h as [7:2]

   typedef enum logic [2:0] {
      K_NONE = 3'b000,
      K_COM  = 3'b001,
      K_CMP  = 3'b010,
      K_DEC  = 3'b011,
      K_INC  = 3'b100,
      K_JP   = 3'b101,
      K_JRC  = 3'b110
   } acsb_kind_t;

   typedef enum logic [3:0] {
      L_A   = 4'b0000,
      L_X   = 4'b0001,
      L_Y   = 4'b0010,
      L_V   = 4'b0011,
      L_W   = 4'b0100,
      L_MEM = 4'b0101,
      L_IMM = 4'b0110,
      L_IX  = 4'b0111,
      L_IY  = 4'b1000,
      L_DIR = 4'b1001
   } acsb_loc_t;

   typedef enum logic [1:0] {
      ST_FETCH = 2'b00,
      ST_ARG   = 2'b01,
      ST_EXEC  = 2'b10,
      ST_WB    = 2'b11
   } acsb_state_t;

   typedef struct packed {
      acsb_kind_t kind;
      logic       two_byte;
      acsb_loc_t  loc;
   } acsb_dec_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       we;
      logic       re;
   } acsb_ds_req_t;

   typedef struct packed {
      logic [7:0] acc;
      logic       null_result_bit;
      logic       arith_flag_bit;
      logic       fetch;
      logic       bad_opcode;
   } acsb_stat_t;

endpackage

// ===== tb/acc_compare_step_branch_ops_tb_top.sv
// testbench: random instruction stream checked against a reference of the core state
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin mismatches++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); end end
module acc_compare_step_branch_ops_tb_top;
   typedef struct packed {logic [11:0] pc; logic [7:0] acc; logic z; logic c;} acsb_note_t;
   logic                   ref_clk = 1'b0;
   logic                   rst_n = 1'b0;
   logic [11:0]            pm_addr;
   logic [7:0]             pm_rdata;
   logic [7:0]             ds_rdata;
   acsb_pkg::acsb_ds_req_t ds_req;
   acsb_pkg::acsb_stat_t   status;
   acsb_note_t             notes[$];
   acsb_note_t             n;
   int                     mismatches = 0;
   int                     samples_checked = 0;
   logic [31:0]            seed = 32'h8826;
   logic [11:0]            pc, t;
   logic [7:0]             acc, x, a, b, r;
   logic [7:0]             exp_ds [256];
   logic [4:0]             e;
   logic                   z, c, d;
   always #50 ref_clk = ~ref_clk;
   acsb_core acsb_core_inst (.ref_clk(ref_clk), .rst_n(rst_n), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
      .ds_req(ds_req), .ds_rdata(ds_rdata), .status(status));
   acsb_mem_model acsb_mem_model_inst (.ref_clk(ref_clk), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
      .ds_req(ds_req), .ds_rdata(ds_rdata));
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   task automatic put(input logic [7:0] v);
      acsb_mem_model_inst.pm[pc] = v;
      pc++;
   endtask
   task automatic cmp_to(input logic [7:0] src);
      z = (acc == src);
      c = (acc < src);
   endtask
   task automatic step(inout logic [7:0] v, input logic dn);
      v = dn ? v - 8'h01 : v + 8'h01;
      z = (v == 8'h00);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // result watcher
   // ------------------------------------------------------------
   // each later fetch closes one instruction; reset is released by nba so the opening fetch is never seen
   always @(negedge ref_clk) begin
      if (rst_n && status.fetch === 1'b1 && notes.size() != 0) begin
         n = notes.pop_front();
         `CHK("program counter", n.pc, pm_addr)
         `CHK("accumulator", n.acc, status.acc)
         `CHK("zero flag", n.z, status.null_result_bit)
         `CHK("carry flag", n.c, status.arith_flag_bit)
      end
   end
   // build program and data, noting the state expected after each instruction
   initial begin
      {pc, acc, x, z, c} = '0;
      for (int i = 0; i < 256; i++) begin
         b = rnd();
         exp_ds[i] = b[7] ? ({8{b[0]}} ^ {7'h00, b[1]}) : b; // many values next to zero
         acsb_mem_model_inst.ds[i] = exp_ds[i];
      end
      for (int i = 0; i < 300; i++) begin
         b = rnd();
         a = rnd() & 8'h7f; // direct space kept clear of register aliases
         d = (x == 8'h00) ? 1'b0 : ((x == 8'h7f) ? 1'b1 : b[0]);
         case (b[7:4] % 4'd10)
            4'd0: begin
               if (b[3]) begin
                  put(8'h00); // unsupported opcode acts as a one-byte no-op
               end else begin
                  put(8'h2d);
                  c = acc[7];
                  acc = ~acc;
                  z = (acc == 8'h00);
               end
            end
            4'd1: begin
               r = b[1] ? acc : rnd();
               put(8'h37);
               put(r);
               cmp_to(r);
            end
            4'd2: begin
               put(b[1] ? 8'h27 : 8'h2f);
               cmp_to(exp_ds[b[1] ? x : 8'h00]);
            end
            4'd3: begin
               put(8'h3f);
               put(a);
               cmp_to(exp_ds[a]);
            end
            4'd4: begin
               put(d ? 8'hff : 8'h7f);
               put(8'hff);
               step(acc, d);
            end
            4'd5: begin
               put(d ? 8'h1d : 8'h15);
               step(x, d);
            end
            4'd6: begin
               put(d ? 8'he7 : 8'h67);
               step(exp_ds[x], d);
            end
            4'd7: begin
               put(d ? 8'hff : 8'h7f);
               put(a);
               step(exp_ds[a], d);
            end
            4'd8: begin
               t = pc + 12'h002 + {10'h000, b[3:2]};
               put({t[3:0], 4'h9});
               put(t[11:4]);
               while (pc != t) put(8'h2d); // skipped bytes would corrupt the accumulator
            end
            default: begin
               e = c ? {1'b0, b[3:0]} : b[4:0]; // backward only when it must fall through
               put({e, 3'b110});
               if (c) repeat (e) put(8'h2d);
            end
         endcase
         notes.push_back('{pc, acc, z, c});
      end
      t = pc;
      put({t[3:0], 4'h9});
      put(t[11:4]);
      repeat (3) @(negedge ref_clk);
      rst_n <= 1'b1;
      for (int w = 0; w < 5000 && notes.size() != 0; w++) @(negedge ref_clk);
      if (notes.size() != 0) begin
         mismatches++;
         $display("CHECK FAILED instruction stream expected 0 seen %0d", notes.size());
      end
      $display("test instruction_stream done");
      for (int i = 0; i < 128; i++) begin
         `CHK("data byte", exp_ds[i], acsb_mem_model_inst.ds[i])
      end
      $display("test data_space done");
      finish_test();
   end
endmodule
`default_nettype wire

// ===== tb/acsb_core_assertions.sv
// checker: port relations of the complement, compare, step and branch core
`timescale 1ns/10ps
`default_nettype none
module acsb_core_assertions (
   // clock and reset
   input wire logic                   ref_clk,
   input wire logic                   rst_n,
   // memories
   input wire logic [11:0]            pm_addr,
   input wire logic [7:0]             pm_rdata,
   input wire acsb_pkg::acsb_ds_req_t ds_req,
   input wire logic [7:0]             ds_rdata,
   // core state
   input wire acsb_pkg::acsb_stat_t   status
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic [7:0]  op_ff;
   logic [11:0] opc_ff;
   logic [11:0] rel_tgt;
   logic        f;
   logic        z;
   logic        c;
   // ------------------------------------------------------------
   // opcode history
   // ------------------------------------------------------------
   // held from the fetch, since results are judged up to four cycles later
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         op_ff  <= 8'h00;
         opc_ff <= 12'h000;
      end else if (status.fetch) begin
         op_ff  <= pm_rdata;
         opc_ff <= pm_addr;
      end
   end
   // displacement counts from the byte after the one-byte branch
   assign f = status.fetch;
   assign z = status.null_result_bit;
   assign c = status.arith_flag_bit;
   assign rel_tgt = opc_ff + 12'h001 + {{7{op_ff[7]}}, op_ff[7:3]};
   invert_result_a: assert property (f && pm_rdata == 8'h2d |-> ##4 f && status.acc == ~$past(status.acc, 4))
      else $error("complement result wrong");
   invert_flags_a: assert property (f && pm_rdata == 8'h2d |-> ##4 c == ~status.acc[7] && z == (status.acc == 8'h00))
      else $error("complement flags wrong");
   cmp_keeps_acc_a: assert property (f && pm_rdata inside {8'h27, 8'h2f, 8'h3f, 8'h37}
      |-> ##4 f && status.acc == $past(status.acc, 4)) else $error("compare altered accumulator");
   cmp_imm_flags_a: assert property (f && pm_rdata == 8'h37 |-> ##4 c == (status.acc < $past(pm_rdata, 3))
      && z == (status.acc == $past(pm_rdata, 3))) else $error("immediate compare flags wrong");
   step_carry_a: assert property (f && (pm_rdata inside {8'hff, 8'he7, 8'hef, 8'h7f, 8'h67, 8'h6f}
      || pm_rdata[5:0] inside {6'h1d, 6'h15}) |-> ##4 f && c == $past(c, 4)) else $error("step changed carry");
   step_write_a: assert property (f && pm_rdata inside {8'he7, 8'h67} |-> ##3 ds_req.we
      && ds_req.wdata == (op_ff[7] ? $past(ds_rdata) - 8'h01 : $past(ds_rdata) + 8'h01)
      ##1 z == ($past(ds_req.wdata) == 8'h00)) else $error("indirect step write wrong");
   abs_jump_a: assert property (f && pm_rdata[3:0] == 4'h9 |-> ##4 f && pm_addr == {$past(pm_rdata, 3), op_ff[7:4]}
      && z == $past(z, 4) && c == $past(c, 4)) else $error("absolute jump wrong");
   rel_branch_a: assert property (f && pm_rdata[2:0] == 3'b110 |-> ##2 f
      && pm_addr == ($past(c, 2) ? rel_tgt : opc_ff + 12'h001) && z == $past(z, 2) && c == $past(c, 2))
      else $error("relative branch wrong");
   pc_one_a: assert property (f && pm_rdata inside {8'h2d, 8'h27, 8'h2f} |-> ##4 pm_addr == $past(pm_addr, 4) + 12'h001)
      else $error("one-byte advance wrong");
   pc_two_a: assert property (f && pm_rdata inside {8'h37, 8'h3f} |-> ##4 pm_addr == $past(pm_addr, 4) + 12'h002)
      else $error("two-byte advance wrong");
   cover property (f && pm_rdata[2:0] == 3'b110 && c);
   cover property (f && pm_rdata[3:0] == 4'h9);
   bad_opcode_a: assert property (f && pm_rdata == 8'h00 |=> status.bad_opcode ##3 f
      && pm_addr == $past(pm_addr, 4) + 12'h001) else $error("unsupported opcode handling wrong");
   read_strobe_a: assert property (f && pm_rdata inside {8'h27, 8'h2f, 8'he7, 8'h67} |-> ##2 ds_req.re)
      else $error("indirect read strobe missing");
   cover property (ds_req.we);
   cover property (status.bad_opcode);
endmodule
bind acsb_core acsb_core_assertions acsb_core_assertions_inst (.ref_clk(ref_clk), .rst_n(rst_n), .pm_addr(pm_addr),
   .pm_rdata(pm_rdata), .ds_req(ds_req), .ds_rdata(ds_rdata), .status(status));
`default_nettype wire

// ===== tb/acsb_mem_model.sv
// model: program memory and data space memory facing the core
`timescale 1ns/10ps
`default_nettype none
module acsb_mem_model (
   // clock
   input  wire logic                   ref_clk,
   // program side
   input  wire logic [11:0]            pm_addr,
   output logic [7:0]                  pm_rdata,
   // data side
   input  wire acsb_pkg::acsb_ds_req_t ds_req,
   output logic [7:0]                  ds_rdata
);
   logic [7:0] pm [4096];
   logic [7:0] ds [256];
   // reads are combinational; the bench loads both arrays before reset ends
   assign pm_rdata = pm[pm_addr];
   assign ds_rdata = ds[ds_req.addr];
   // write lands on the edge that ends the strobe cycle
   always @(posedge ref_clk) begin
      if (ds_req.we === 1'b1) ds[ds_req.addr] <= ds_req.wdata;
   end
endmodule
`default_nettype wire
